// ==== src/tw_defs.svh ====
// Operation
// - data is sampled on rising scl and shifted out on falling scl
// - sda is only pulled low or released, never driven high
// - three chip-select pins let eight devices share one bus
// - an unconnected chip-select pin counts as low; the code has no pull-down, and only the synchroniser reset loads zeros
// - write-protect low allows normal reads and writes to the whole array
// - write-protect high blocks all writes, reads still allowed
// - array holds 128 or 256 pages of 32 bytes
// - word address is 12 bits small variant, 13 bits large variant
// - write cycle starts at stop after a write, self-timed, done within 5 ms
// - partial page writes commit only the bytes received
// - sda changes only while scl low; changes while scl high are start/stop
// - sda falling with scl high is a start and begins a transfer
// - sda rising with scl high is a stop and ends the transfer
// - stop after a read puts the device straight into standby
// - 8-bit words, device pulls sda low on ninth clock as acknowledge
// - standby at power-up and after stop once internal work is done
// - first byte is 1010, three chip-select bits, then read/write bit
// - chip-select mismatch gives no acknowledge and returns to standby
// - page write advances only the low five address bits, wrapping in page
// - no address acknowledge while a write cycle is running
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

`define TW_ADDR_W 13
`define TW_MEM_BYTES 8192
`define TW_PAGE_BYTES 32
`define TW_PAGE_W 5
`define TW_DEV_PREFIX 4'ha
`define TW_CLK_MHZ 100
`define TW_WR_TIME_MS 5
`define TW_WR_CYCLES (`TW_WR_TIME_MS * 1000 * `TW_CLK_MHZ)
`define TW_CNT_W 20
`define TW_PACE_DIV 4
`define TW_PIN_RST 6'h03

`endif

// ==== src/tw_pkg.sv ====
package tw_pkg;

  // protocol states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_DEV  = 8'h02,
    ST_AHI  = 8'h04,
    ST_ALO  = 8'h08,
    ST_DATA = 8'h10,
    ST_ACK  = 8'h20,
    ST_RD   = 8'h40,
    ST_RACK = 8'h80
  } tw_state_t;

endpackage : tw_pkg

// ==== src/tw_buf2.sv ====
`timescale 1ns/1ps
module tw_buf2 #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] ent_q [2];
  logic [W-1:0] ent_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  // =====================================
  // handshake
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = ent_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // next pointers and entries
  always_comb begin
    ent_d = ent_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      ent_d[wp_q] = in_data;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    ent_q <= ent_d;
  end

endmodule : tw_buf2

// ==== src/tw_eeprom.sv ====
`timescale 1ns/1ps
`include "tw_defs.svh"
module tw_eeprom import tw_pkg::*; #(
  parameter int unsigned WR_CYCLES = `TW_WR_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic wp_i,
  input wire logic [2:0] chip_select_address_pins,
  output logic standby,
  output logic write_busy
);

  localparam logic [`TW_CNT_W-1:0] WR_LAST = `TW_CNT_W'(WR_CYCLES - 1);
  localparam logic [1:0] PACE_LAST = 2'(`TW_PACE_DIV - 1);
  localparam int FW = 8 + `TW_ADDR_W;

  // =====================================
  // pin synchronisers
  logic [5:0] pin_s1_q, pin_s2_q;
  logic scl_s3_q, sda_s3_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_q <= `TW_PIN_RST;
      pin_s2_q <= `TW_PIN_RST;
      scl_s3_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= {chip_select_address_pins, wp_i, sda_i, scl_i};
      pin_s2_q <= pin_s1_q;
      scl_s3_q <= pin_s2_q[0];
      sda_s3_q <= pin_s2_q[1];
    end
  end

  logic scl_now, sda_now, wp_now, scl_rise, scl_fall, start_det, stop_det;
  logic [2:0] cs_now;

  // edge and condition detection on the second stage
  assign scl_now = pin_s2_q[0];
  assign sda_now = pin_s2_q[1];
  assign wp_now = pin_s2_q[2];
  assign cs_now = pin_s2_q[5:3];
  assign scl_rise = scl_now & ~scl_s3_q;
  assign scl_fall = ~scl_now & scl_s3_q;
  assign start_det = scl_now & scl_s3_q & sda_s3_q & ~sda_now;
  assign stop_det = scl_now & scl_s3_q & ~sda_s3_q & sda_now;

  // =====================================
  // storage
  logic [7:0] mem_q [`TW_MEM_BYTES];
  logic [7:0] pbuf_q [`TW_PAGE_BYTES];
  logic [7:0] pbuf_d [`TW_PAGE_BYTES];

  // =====================================
  // protocol engine
  tw_state_t state_q, state_d, ret_q, ret_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [`TW_ADDR_W-1:0] addr_q, addr_d, addr_inc;
  logic [7:0] page_q, page_d;
  logic [31:0] mask_q, mask_d;
  logic wr_pend_q, wr_pend_d, mack_q, mack_d, oe_q, oe_d;
  logic commit_go, busy_q;

  assign addr_inc = addr_q + `TW_ADDR_W'(1);

  // next protocol state
  always_comb begin
    state_d = state_q;
    ret_d = ret_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    page_d = page_q;
    mask_d = mask_q;
    pbuf_d = pbuf_q;
    wr_pend_d = wr_pend_q;
    mack_d = mack_q;
    commit_go = 1'b0;
    if (stop_det) begin
      commit_go = wr_pend_q & ~wp_now;
      wr_pend_d = 1'b0;
      state_d = ST_IDLE;
    end else if (start_det) begin
      state_d = ST_DEV;
      cnt_d = 4'h0;
      wr_pend_d = 1'b0;
    end else begin
      case (state_q)
        ST_DEV, ST_AHI, ST_ALO, ST_DATA: begin
          if (scl_rise && cnt_q < 4'h8) begin
            sh_d = {sh_q[6:0], sda_now};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            state_d = ST_ACK;
            case (state_q)
              ST_DEV: begin
                if (sh_q[7:4] == `TW_DEV_PREFIX && sh_q[3:1] == cs_now && !busy_q) begin
                  ret_d = sh_q[0] ? ST_RD : ST_AHI;
                end else begin
                  state_d = ST_IDLE;
                end
              end
              ST_AHI: begin
                addr_d[`TW_ADDR_W-1:8] = sh_q[`TW_ADDR_W-9:0];
                ret_d = ST_ALO;
              end
              ST_ALO: begin
                addr_d[7:0] = sh_q;
                page_d = {addr_q[`TW_ADDR_W-1:8], sh_q[7:5]};
                mask_d = 32'h0;
                ret_d = ST_DATA;
              end
              default: begin
                pbuf_d[addr_q[4:0]] = sh_q;
                if (!wp_now) begin
                  mask_d[addr_q[4:0]] = 1'b1;
                  wr_pend_d = 1'b1;
                end
                addr_d[4:0] = addr_q[4:0] + 5'h1;
                ret_d = ST_DATA;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_d = ret_q;
            cnt_d = 4'h0;
            if (ret_q == ST_RD) begin
              sh_d = mem_q[addr_q];
            end
          end
        end
        ST_RD: begin
          if (scl_rise && cnt_q < 4'h8) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            state_d = ST_RACK;
            cnt_d = 4'h0;
          end else if (scl_fall && cnt_q != 4'h0) begin
            sh_d = {sh_q[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_d = ~sda_now;
            cnt_d = 4'h1;
          end else if (scl_fall && cnt_q == 4'h1) begin
            addr_d = addr_inc;
            cnt_d = 4'h0;
            if (mack_q) begin
              sh_d = mem_q[addr_inc];
              state_d = ST_RD;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    // only ever pull low: ninth clock ack or a zero data bit
    oe_d = (state_d == ST_ACK) | ((state_d == ST_RD) & ~sh_d[7]);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= '0;
      page_q <= 8'h00;
      mask_q <= 32'h0;
      wr_pend_q <= 1'b0;
      mack_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ret_q <= ret_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      page_q <= page_d;
      mask_q <= mask_d;
      wr_pend_q <= wr_pend_d;
      mack_q <= mack_d;
      oe_q <= oe_d;
    end
    pbuf_q <= pbuf_d;
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;

  // =====================================
  // self-timed write cycle
  logic [`TW_CNT_W-1:0] tmr_q, tmr_d;
  logic [5:0] scan_q, scan_d;
  logic [1:0] pace_q, pace_d;
  logic busy_d, push_v, push_rdy, pop_v, pace_hit;
  logic [FW-1:0] push_data, pop_data;

  assign pace_hit = (pace_q == PACE_LAST);
  assign push_v = busy_q & ~scan_q[5] & mask_q[scan_q[4:0]];
  assign push_data = {page_q, scan_q[4:0], pbuf_q[scan_q[4:0]]};

  // timer, page scan and pacing divider
  always_comb begin
    tmr_d = tmr_q;
    scan_d = scan_q;
    busy_d = busy_q;
    pace_d = pace_hit ? 2'h0 : pace_q + 2'h1;
    if (commit_go) begin
      busy_d = 1'b1;
      tmr_d = '0;
      scan_d = 6'h0;
    end else if (busy_q) begin
      if (tmr_q != WR_LAST) begin
        tmr_d = tmr_q + `TW_CNT_W'(1);
      end
      if (!scan_q[5] && (!mask_q[scan_q[4:0]] || push_rdy)) begin
        scan_d = scan_q + 6'h1;
      end
      if (tmr_q == WR_LAST && scan_q[5] && !pop_v) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmr_q <= '0;
      scan_q <= 6'h20;
      busy_q <= 1'b0;
      pace_q <= 2'h0;
    end else begin
      tmr_q <= tmr_d;
      scan_q <= scan_d;
      busy_q <= busy_d;
      pace_q <= pace_d;
    end
  end

  // staged bytes queue up for the paced array writer
  tw_buf2 #(.W(FW)) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_data),
    .out_valid(pop_v),
    .out_ready(pace_hit),
    .out_data(pop_data)
  );

  // array write, nonvolatile so no reset
  always_ff @(posedge mclk) begin
    if (pop_v && pace_hit) begin
      mem_q[pop_data[FW-1:8]] <= pop_data[7:0];
    end
  end

  assign write_busy = busy_q;
  assign standby = (state_q == ST_IDLE) & ~busy_q;

endmodule : tw_eeprom

// ==== test/tw_asserts.sv ====
`timescale 1ns/1ps
// ==========
// pin-level checks of the device side
module tw_chk #(
  parameter int unsigned WR_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic wp_i,
  input wire logic [2:0] chip_select_address_pins,
  input wire logic standby,
  input wire logic write_busy
);
  localparam int BUSY_LO = WR_CYCLES - 2;
  localparam int BUSY_HI = WR_CYCLES + 8;
  logic [19:0] busy_d;
  logic [19:0] busy_q;
  // length of the running write cycle
  always_comb begin
    busy_d = write_busy ? busy_q + 20'h00001 : 20'h00000;
  end
  always_ff @(posedge mclk) begin
    busy_q <= rst_n ? busy_d : 20'h00000;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_pull_only: assert property (sda_oe |-> !sda_o)
    else $error("sda high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved in scl high");
  a_start_wakes: assert property (scl_i && $fell(sda_i)
    |-> ##[1:8] !standby)
    else $error("start missed");
  a_stop_rests: assert property (scl_i && $rose(sda_i)
    |-> ##[1:8] (standby || write_busy))
    else $error("stop missed");
  a_busy_mute: assert property (write_busy |-> !sda_oe)
    else $error("ack while busy");
  a_busy_awake: assert property (write_busy |-> !standby)
    else $error("standby while busy");
  a_reset_idle: assert property ($rose(rst_n)
    |-> standby && !write_busy && !sda_oe)
    else $error("not idle");
  a_cycle_len: assert property ($fell(write_busy)
    |-> int'(busy_q) inside {[BUSY_LO:BUSY_HI]})
    else $error("cycle length");
  c_write: cover property ($rose(write_busy));
  c_ack: cover property ($rose(sda_oe));
  c_rest: cover property ($rose(standby));
endmodule : tw_chk
bind tw_eeprom tw_chk #(.WR_CYCLES(WR_CYCLES)) tw_chk_inst (.mclk(mclk), .rst_n(rst_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i),
  .chip_select_address_pins(chip_select_address_pins), .standby(standby),
  .write_busy(write_busy));

// ==== test/tw_ctl.sv ====
`timescale 1ns/1ps
// ==========
// bus controller model: owns scl, pulls sda low or lets it float
module tw_ctl (
  input wire logic mclk,
  input wire logic sda_i,
  output logic scl,
  output logic sda_pull
);
  logic [7:0] res_d = 8'h00;
  logic framed = 1'b0;
  event got;
  // idle bus: clock stands high, data released
  task automatic idle();
    scl <= 1'b1;
    sda_pull <= 1'b0;
  endtask : idle
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // one clock: data set while scl low, read after the rise
  task automatic slot(input logic b, output logic s);
    scl <= 1'b0;
    tick(1);
    sda_pull <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(1);
    s = sda_i;
    tick(2);
  endtask : slot
  // pull high gives a start, pull low a stop, both with scl high
  task automatic mark(input logic pull);
    if (framed) begin
      scl <= 1'b0;
      tick(1);
      sda_pull <= ~pull;
      tick(4);
      scl <= 1'b1;
      tick(2);
    end
    sda_pull <= pull;
    framed = pull;
    tick(3);
  endtask : mark
  // data bits msb first, then the acknowledge clock
  task automatic put_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    res_d = {7'h00, s};
    -> got;
  endtask : put_byte
  // read a byte, then acknowledge to go on or not to end
  task automatic get_byte(input logic more);
    logic s;
    for (int i = 0; i < 8; i++) begin
      slot(1'b1, s);
      res_d = {res_d[6:0], s};
    end
    slot(~more, s);
    -> got;
  endtask : get_byte
  // up to nine released clocks, stopping once sda is seen high with scl high
  task automatic recover();
    logic s;
    s = 1'b0;
    for (int i = 0; i < 9 && s !== 1'b1; i++) slot(1'b1, s);
  endtask : recover
endmodule : tw_ctl

// ==== test/two_wire_eeprom_slave_tb_top.sv ====
`timescale 1ns/1ps
// ==========
// bench top: controller model on the bus, expected results in a queue
module two_wire_eeprom_slave_tb_top;
  logic mclk;
  logic rst_n;
  logic wp_i;
  logic [2:0] pins;
  logic sda_o, sda_oe, standby, write_busy, scl, sda_pull;
  logic [7:0] exp_q[$];
  logic [7:0] pg[32];
  logic [31:0] seed = 32'ha475;
  logic [2:0] cs = 3'h0;
  logic [12:0] base;
  int error_cnt = 0;
  int comparisons = 0;
  wire sda = ~(sda_oe | sda_pull); // open drain with pull-up
  tw_eeprom #(.WR_CYCLES(200)) tw_eeprom_inst (.mclk(mclk), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i),
    .chip_select_address_pins(pins), .standby(standby), .write_busy(write_busy));
  tw_ctl tw_ctl_inst (.mclk(mclk), .sda_i(sda), .scl(scl), .sda_pull(sda_pull));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic put(input logic [7:0] d, input logic [7:0] e);
    exp_q.push_back(e);
    tw_ctl_inst.put_byte(d);
  endtask : put
  task automatic get(input logic [7:0] e, input logic more);
    exp_q.push_back(e);
    tw_ctl_inst.get_byte(more);
  endtask : get
  // address the device, load the pointer, optionally turn to reading
  task automatic seek(input logic [12:0] a, input logic rd);
    tw_ctl_inst.mark(1'b1);
    put({4'ha, cs, 1'b0}, 8'h00);
    put({3'h0, a[12:8]}, 8'h00);
    put(a[7:0], 8'h00);
    if (rd) begin
      tw_ctl_inst.mark(1'b1);
      put({4'ha, cs, 1'b1}, 8'h00);
    end
  endtask : seek
  task automatic fin(input string n);
    tw_ctl_inst.mark(1'b0);
    for (int i = 0; i < 300 && standby !== 1'b1; i++) @(posedge mclk);
    chk({7'h00, standby}, 8'h01);
    $display("test %s done", n);
  endtask : fin
  // each reported byte or acknowledge against the oldest note
  initial forever begin
    @(tw_ctl_inst.got);
    chk(tw_ctl_inst.res_d, exp_q.size() > 0 ? exp_q.pop_front() : 8'hee);
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  // main sequence
  initial begin
    rst_n <= 1'b0;
    wp_i <= 1'b0;
    pins <= 3'h0;
    tw_ctl_inst.idle();
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({6'h00, standby, write_busy}, 8'h02);
    for (int k = 0; k < 8; k++) begin
      pins <= 3'(k);
      cs = 3'(k);
      repeat (4) @(posedge mclk);
      tw_ctl_inst.mark(1'b1);
      put({4'ha, cs ^ 3'h1, 1'b0}, 8'h01);
      tw_ctl_inst.mark(1'b1);
      put({4'hb, cs, 1'b0}, 8'h01);
      tw_ctl_inst.mark(1'b1);
      put({4'ha, cs, 1'b0}, 8'h00);
      fin("select");
    end
    cs = 3'(rnd());
    pins <= cs;
    base = {rnd(), 5'h00};
    seek(base + 13'd30, 1'b0);
    for (int i = 0; i < 34; i++) begin
      pg[(30 + i) % 32] = rnd();
      put(pg[(30 + i) % 32], 8'h00);
    end
    tw_ctl_inst.mark(1'b0);
    tw_ctl_inst.mark(1'b1);
    put({4'ha, cs, 1'b0}, 8'h01);
    fin("page write");
    seek(base, 1'b1);
    for (int i = 0; i < 32; i++) get(pg[i], i < 31);
    fin("page read");
    seek(base + 13'd5, 1'b0);
    pg[5] = rnd();
    put(pg[5], 8'h00);
    fin("partial");
    seek(base + 13'd4, 1'b1);
    for (int i = 4; i < 7; i++) get(pg[i], i < 6);
    tw_ctl_inst.mark(1'b0);
    tw_ctl_inst.mark(1'b1);
    put({4'ha, cs, 1'b1}, 8'h00);
    get(pg[7], 1'b0);
    fin("current read");
    tw_ctl_inst.mark(1'b1);
    put({4'ha, cs, 1'b0}, 8'h00);
    tw_ctl_inst.recover();
    wp_i <= 1'b1;
    seek(base, 1'b0);
    put(~pg[0], 8'h00);
    tw_ctl_inst.mark(1'b0);
    repeat (8) @(posedge mclk);
    chk({6'h00, standby, write_busy}, 8'h02);
    wp_i <= 1'b0;
    seek(base, 1'b1);
    get(pg[0], 1'b0);
    fin("protect");
    wrap_up();
  end
endmodule : two_wire_eeprom_slave_tb_top
